// [temp_regs_pkg.sv]
// Package with register map, field layout, reset values and timing counts.
package temp_regs_pkg;

   // Register pointers.
   localparam logic [7:0] PTR_RESULT     = 8'h05;
   localparam logic [7:0] PTR_MAKER      = 8'h06;
   localparam logic [7:0] PTR_PART_REV   = 8'h07;
   localparam logic [7:0] PTR_RESOLUTION = 8'h08;

   // Result register fields.
   localparam int RES_CRIT_BIT = 15;
   localparam int RES_HIGH_BIT = 14;
   localparam int RES_LOW_BIT  = 13;
   localparam int RES_TEMP_MSB = 12;
   localparam int CMP_LSB      = 2;

   // Resolution register field position and reset value.
   localparam int RESF_LSB = 3;
   localparam logic [1:0]  RESF_RESET   = 2'h1;
   localparam logic [15:0] RESREG_RESET = 16'h0008;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Identity codes, values arbitrary.
   localparam logic [15:0] MAKER_CODE = 16'h1234;
   localparam logic [7:0]  PART_CODE  = 8'h5a;
   localparam logic [7:0]  REV_CODE   = 8'h01;

   // Hysteresis codes in units of 0.25 degrees (compare-bit LSB).
   localparam logic [10:0] HYST_0  = 11'h000;
   localparam logic [10:0] HYST_15 = 11'h006;
   localparam logic [10:0] HYST_3  = 11'h00c;
   localparam logic [10:0] HYST_6  = 11'h018;

   // Conversion period.
   localparam int CONV_TIME_MS = 100;
   localparam int CLK_MHZ      = 250;
   localparam int CONV_CYCLES  = CONV_TIME_MS * 1000 * CLK_MHZ;

   // Limit set used by the status comparators.
   typedef struct packed {
      logic [12:0] crit;
      logic [12:0] high;
      logic [12:0] low;
      logic [1:0]  hyst;
   } limits_t;

   // Host register access.
   typedef struct packed {
      logic        wr;
      logic [7:0]  ptr;
      logic [15:0] wdata;
   } reg_req_t;

endpackage

// [temp_result_status_regs.sv]
// Result, status flags, identity and resolution registers of a temp sensor.
// Functional notes
// RL1 - Read-only result at pointer 05: three flags above 13-bit signed value.
// RL2 - Bit 12 sign, bit 11 is 128 degrees, halving to 0.0625 at bit 0.
// RL3 - Fraction bits finer than selected resolution read as zero.
// RL4 - Bit 15 sets above critical, clears below critical minus hysteresis.
// RL5 - Bit 14 sets above high, clears at or below high minus hysteresis.
// RL6 - Bit 13 sets below low minus hysteresis, clears at or above low.
// RL7 - Pointer 06 returns a fixed 16-bit maker code.
// RL8 - Pointer 07 returns part code in upper byte, revision in lower.
// RL9 - Resolution register at pointer 08, reset selects 0.25 degrees.
// RL10 - Field bits 4:3 select 0.5, 0.25, 0.125 or 0.0625 degree LSB.
// RL11 - Written resolution is mirrored into the capabilities field.
// RL12 - Each conversion finishes within 100 ms, then result refreshes.
// RL13 - Hysteresis code: 00 none, 01 1.5, 10 3, 11 6 degrees.
// RL14 - Flag comparisons use only result bits 12 down to 2.
// RL15 - While powered down, no conversion and result stays unchanged.
// RL16 - Result and limits are two's complement.
// RL17 - Value and flags update together at end of a conversion.
module temp_result_status_regs #(
   parameter int CONV_CYCLES_P = temp_regs_pkg::CONV_CYCLES
) (
   // Clock and reset.
   input  wire  logic                      clk,
   input  wire  logic                      rst,
   // Register access from the serial port.
   input  wire  temp_regs_pkg::reg_req_t   req,
   output logic [15:0]                     rdata,
   // Sensor and control.
   input  wire  logic [12:0]               adc_temp,
   input  wire  temp_regs_pkg::limits_t    limits,
   input  wire  logic                      power_down_control,
   output logic [1:0]                      cap_resolution_field,
   output logic                            conv_done
);
   import temp_regs_pkg::*;

   typedef enum logic {IDLE, RUN} conv_state_t;

   // Conversion timer.
   conv_state_t state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic        done_q, done_d;

   // Resolution register and capability mirror.
   logic [1:0]  resolution_field_q, resolution_field_d;
   logic [1:0]  cap_q, cap_d;

   // Stored result value and status flags.
   logic [12:0] value_q, value_d;
   logic        crit_q, crit_d;
   logic        high_q, high_d;
   logic        low_q, low_d;

   // Read data.
   logic [15:0] rdata_d;

   // Sample path shared by the value and the comparators.
   wire logic [12:0]   keep_mask;
   logic [12:0]        temp_masked;
   logic signed [11:0] t_x, crit_x, high_x, low_x, hyst_x;

   ////////////////////////////////////////////////////////////////////////
   // Resolution register and capability mirror.
   always_comb begin
      resolution_field_d = resolution_field_q;
      cap_d = cap_q;
      if (req.wr && req.ptr == PTR_RESOLUTION) begin
         resolution_field_d = req.wdata[RESF_LSB +: 2]; // [RL10]
         cap_d = req.wdata[RESF_LSB +: 2]; // [RL11]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         resolution_field_q <= RESF_RESET; // [RL9]
         cap_q <= RESF_RESET;
      end else begin
         resolution_field_q <= resolution_field_d;
         cap_q <= cap_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion timer; a free-running period of exactly CONV_CYCLES_P cycles, the full 100 ms limit by default.
   // Power down parks the timer; resume restarts a full period.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      unique case (state_q)
         IDLE: begin
            if (!power_down_control) begin // [RL15]
               state_d = RUN;
               cnt_d = '0;
            end
         end
         RUN: begin
            if (power_down_control) begin // [RL15]
               state_d = IDLE;
            end else if (cnt_q == 32'(CONV_CYCLES_P - 1)) begin // [RL12]
               cnt_d = '0;
               done_d = 1'b1;
            end else begin
               cnt_d = cnt_q + 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= IDLE;
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Resolution mask: bits 12:3 (down to 0.5 degrees) always kept, bits 2:0 by field.
   // A kept bit passes the sample; a dropped bit reads as zero.
   for (genvar b = 0; b <= RES_TEMP_MSB; b++) begin : g_mask
      if (b >= 3) begin : g_int
         assign keep_mask[b] = 1'b1;
      end else begin : g_frac
         assign keep_mask[b] = (resolution_field_q >= 2'(3 - b)); // [RL3]
      end
   end

   // Masking when stored, not at read, keeps stored value and reads alike.
   assign temp_masked = adc_temp & keep_mask; // [RL10]

   ////////////////////////////////////////////////////////////////////////
   // Comparator operands, one bit wider than the compare field.
   always_comb begin
      unique case (limits.hyst) // [RL13]
         2'h0: hyst_x = 12'(HYST_0);
         2'h1: hyst_x = 12'(HYST_15);
         2'h2: hyst_x = 12'(HYST_3);
         2'h3: hyst_x = 12'(HYST_6);
      endcase
      // The extra bit keeps a limit minus hysteresis from wrapping at -256.
      // Bits finer than 0.25 degrees never reach the comparators.
      t_x    = 12'($signed(temp_masked[RES_TEMP_MSB:CMP_LSB])); // [RL14]
      crit_x = 12'($signed(limits.crit[RES_TEMP_MSB:CMP_LSB]));
      high_x = 12'($signed(limits.high[RES_TEMP_MSB:CMP_LSB]));
      low_x  = 12'($signed(limits.low[RES_TEMP_MSB:CMP_LSB]));
   end

   ////////////////////////////////////////////////////////////////////////
   // Result and flag update, all from one sample.
   // Hysteresis moves the clear threshold of critical and high, but the set threshold of low.
   always_comb begin
      value_d = value_q;
      crit_d = crit_q;
      high_d = high_q;
      low_d = low_q;
      if (done_d) begin // [RL17]
         value_d = temp_masked; // [RL1] [RL2] [RL16]
         // Critical: set above limit, clear below limit minus hysteresis.
         if (t_x > crit_x) begin
            crit_d = 1'b1; // [RL4]
         end else if (t_x < crit_x - hyst_x) begin
            crit_d = 1'b0;
         end
         // High: set above limit, clear at or below limit minus hysteresis.
         if (t_x > high_x) begin
            high_d = 1'b1; // [RL5]
         end else if (t_x <= high_x - hyst_x) begin
            high_d = 1'b0;
         end
         // Low: set below limit minus hysteresis, clear at or above limit.
         if (t_x < low_x - hyst_x) begin
            low_d = 1'b1; // [RL6]
         end else if (t_x >= low_x) begin
            low_d = 1'b0;
         end
      end
   end

   // Value and flags load on one edge so reads never mix conversions.
   always_ff @(posedge clk) begin
      if (rst) begin
         value_q <= RESULT_RESET[RES_TEMP_MSB:0];
         crit_q <= RESULT_RESET[RES_CRIT_BIT];
         high_q <= RESULT_RESET[RES_HIGH_BIT];
         low_q <= RESULT_RESET[RES_LOW_BIT];
      end else begin
         value_q <= value_d;
         crit_q <= crit_d;
         high_q <= high_d;
         low_q <= low_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped pointers return zero.
   always_comb begin
      unique case (req.ptr)
         PTR_RESULT:     rdata_d = {crit_q, high_q, low_q, value_q}; // [RL1]
         PTR_MAKER:      rdata_d = MAKER_CODE; // [RL7]
         PTR_PART_REV:   rdata_d = {PART_CODE, REV_CODE}; // [RL8]
         PTR_RESOLUTION: rdata_d = 16'(resolution_field_q) << RESF_LSB;
         default:        rdata_d = 16'h0000;
      endcase
   end

   // Registered so read data never follows pointer glitches.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= rdata_d;
      end
   end

   assign cap_resolution_field = cap_q;
   assign conv_done = done_q;

endmodule // temp_result_status_regs

// [temp_regs_assertions.sv]
// Port checks for the temperature register block.
module temp_regs_assertions
   import temp_regs_pkg::*;
#(parameter int CONV_CYCLES_P = 20) (
   input wire logic        clk,
   input wire logic        rst,
   input wire reg_req_t    req,
   input wire logic [15:0] rdata,
   input wire logic        power_down_control,
   input wire logic [1:0]  cap_resolution_field,
   input wire logic        conv_done
);
   localparam int PMAX = CONV_CYCLES_P + 4;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_hold;
      req.ptr == PTR_RESULT ##1 (req.ptr == PTR_RESULT && !conv_done);
   endsequence
   AST_MAKER: assert property (req.ptr == PTR_MAKER |=>
      rdata == MAKER_CODE) else $error("maker code wrong");
   AST_PART: assert property (req.ptr == PTR_PART_REV |=>
      rdata == {PART_CODE, REV_CODE}) else $error("part code wrong");
   AST_RESREG: assert property (req.ptr == PTR_RESOLUTION && !req.wr |=>
      rdata == {11'h0, cap_resolution_field, 3'h0}) else $error("res read");
   AST_MIRROR: assert property (req.wr && req.ptr == PTR_RESOLUTION |=>
      cap_resolution_field == $past(req.wdata[RESF_LSB +: 2]))
      else $error("mirror");
   AST_RESET: assert property ($fell(rst) |-> rdata == 16'h0 &&
      cap_resolution_field == RESF_RESET) else $error("reset values");
   AST_PERIOD: assert property (conv_done |-> ##[1:PMAX]
      (conv_done || power_down_control)) else $error("conversion late");
   AST_SHUTDOWN: assert property (power_down_control [*3] |->
      !conv_done) else $error("converted while down");
   AST_HOLD: assert property (s_hold |=> $stable(rdata))
      else $error("result changed without update");
endmodule // temp_regs_assertions
bind temp_result_status_regs temp_regs_assertions #(
   .CONV_CYCLES_P(CONV_CYCLES_P)) temp_regs_assertions_i (.clk(clk),
   .rst(rst), .req(req), .rdata(rdata), .conv_done(conv_done),
   .power_down_control(power_down_control),
   .cap_resolution_field(cap_resolution_field));

// [temp_host_model.sv]
// Host side model that issues register reads and writes.
module temp_host_model
   import temp_regs_pkg::*;
(
   input  wire logic clk,
   output reg_req_t  req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '{1'b0, PTR_RESULT, 16'h0};
   // Write data is inverted once taken, so stale data never looks valid.
   task automatic acc(input logic w, logic [7:0] p, logic [15:0] d);
      @(negedge clk);
      req = '{w, p, d};
      if (w) begin
         @(negedge clk);
         req = '{1'b0, p, ~d};
      end
   endtask
endmodule // temp_host_model

// [tb_temp_result_status_regs.sv]
// Self-checking bench for the temperature register block.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
$display("Error %0t: got %h expected %h", $time, a, e); end end
module tb_temp_result_status_regs;
   import temp_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0, rst = 1'h1, pd = 1'h0, conv_done;
   logic [12:0] adc = 13'h0abf;
   logic [15:0] rdata;
   logic [1:0]  cap;
   limits_t     lim = '{13'h0ffc, 13'h0ffc, 13'h1000, 2'h0};
   reg_req_t    req;
   int          errors = 0, n_compared = 0;
   always #2 clk = ~clk;
   temp_host_model temp_host_model_i (.clk(clk), .req(req));
   temp_result_status_regs #(.CONV_CYCLES_P(20)) temp_result_status_regs_i (
      .clk(clk), .rst(rst), .req(req), .rdata(rdata), .adc_temp(adc),
      .limits(lim), .power_down_control(pd),
      .cap_resolution_field(cap), .conv_done(conv_done));
   task automatic chk_rd(input logic [7:0] p, logic [15:0] e);
      temp_host_model_i.acc(1'b0, p, 16'h0);
      @(negedge clk);
      `CHK(rdata, e)
   endtask
   // Two completions, so the second has surely sampled the new input.
   task automatic conv2();
      repeat (2) begin
         @(negedge clk);
         for (int n = 0; n < 40 && !conv_done; n++) @(negedge clk);
         if (!conv_done) begin
            errors++;
            $display("Error %0t: no conversion finished", $time);
         end
      end
   endtask
   task automatic t_ids();
      chk_rd(PTR_MAKER, MAKER_CODE);
      chk_rd(PTR_PART_REV, {PART_CODE, REV_CODE});
      chk_rd(PTR_RESOLUTION, 16'h0008);
      chk_rd(8'h09, 16'h0000);
   endtask
   task automatic t_res();
      for (int r = 0; r < 4; r++) begin
         temp_host_model_i.acc(1'b1, PTR_RESOLUTION, 16'(r << 3));
         `CHK(cap, 2'(r))
         chk_rd(PTR_RESOLUTION, 16'(r << 3));
         conv2();
         chk_rd(PTR_RESULT, {3'h0, adc & (13'h1fff << (3 - r))});
      end
      temp_host_model_i.acc(1'b1, PTR_RESULT, 16'hffff);
      chk_rd(PTR_RESULT, 16'h0abf);
      temp_host_model_i.acc(1'b1, PTR_RESOLUTION, 16'h0008);
   endtask
   task automatic t_flags();
      logic [12:0] tv [8] = '{13'h0201, 13'h0283, 13'h01f0, 13'h01e0,
                              13'h0020, 13'h0038, 13'h0040, 13'h1fc0};
      logic [2:0]  fv [8] = '{3'h2, 3'h6, 3'h6, 3'h2, 3'h1, 3'h1, 3'h0, 3'h1};
      lim = '{13'h0200, 13'h0100, 13'h0040, 2'h1};
      for (int i = 0; i < 8; i++) begin
         adc = tv[i];
         conv2();
         chk_rd(PTR_RESULT, {fv[i], tv[i] & 13'h1ffc});
      end
   endtask
   task automatic t_pd();
      pd = 1'b1;
      adc = 13'h0100;
      repeat (60) @(negedge clk);
      chk_rd(PTR_RESULT, 16'h3fc0);
      pd = 1'b0;
      conv2();
      chk_rd(PTR_RESULT, 16'h0100);
   endtask
   task automatic end_of_test();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      end_of_test();
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_ids();
      t_res();
      t_flags();
      t_pd();
      end_of_test();
   end
endmodule // tb_temp_result_status_regs
